// ==== dv/clam_line_model.sv ====
module clam_line_model (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Scenario controls
  input  wire logic rx_on,
  input  wire logic rx_slow,
  input  wire logic tx_on,
  input  wire logic mon_link,
  // Line signals
  output logic      rx_bit_tick,
  output logic      rx_pulse,
  output logic      tx_bit_tick,
  output logic      transmit_out_positive,
  output logic      transmit_out_negative,
  output logic      monitor_in_positive,
  output logic      monitor_in_negative
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cyc_r;
  logic [1:0] ph_r;
  logic       pol_r;
  assign rx_bit_tick = !rx_slow || cyc_r[0];
  // One pulse in three bits sits at the edge of the clearing density.
  assign rx_pulse = rx_on && rx_bit_tick && ph_r == 2'h0;
  assign tx_bit_tick = cyc_r == 2'h0;
  assign transmit_out_positive = tx_on && tx_bit_tick && pol_r;
  assign transmit_out_negative = tx_on && tx_bit_tick && !pol_r;
  // An unlinked monitor pair is terminated and so shows no pulse.
  assign monitor_in_positive = mon_link && transmit_out_positive;
  assign monitor_in_negative = mon_link && transmit_out_negative;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cyc_r <= 2'h0;
      ph_r  <= 2'h0;
      pol_r <= 1'b0;
    end else begin
      cyc_r <= cyc_r + 2'h1;
      if (rx_bit_tick) ph_r <= ph_r == 2'h2 ? 2'h0 : ph_r + 2'h1;
      if (tx_bit_tick) pol_r <= !pol_r;
    end
  end
endmodule : clam_line_model

// ==== dv/clam_monitor.sv ====
module clam_monitor
  import clam_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Line side
  input wire logic       analog_los,
  input wire logic       g775_los,
  input wire logic [5:0] ja_fill,
  input wire logic [5:0] ja_depth,
  input wire logic       tx_bit_tick,
  input wire logic       transmit_out_positive,
  input wire logic       transmit_out_negative,
  input wire logic       monitor_in_positive,
  input wire logic       monitor_in_negative
);
  logic [7:0]  ctl_r;
  logic [7:0]  idle_r;
  logic [22:0] snap_r;
  logic [22:0] snap;
  logic        calm;
  logic        near;
  logic        pulse;
  assign snap = {ctl_r, ja_fill, ja_depth, analog_los, g775_los, tx_bit_tick};
  // Status is judged only when its inputs held still for a cycle.
  assign calm = reg_rd && reg_addr == ADDR_STATUS && snap == snap_r
             && !tx_bit_tick;
  assign near = ja_fill <= 6'h02 || ja_fill + 6'h02 >= ja_depth;
  assign pulse = ctl_r[CTL_DMO_INT]
               ? transmit_out_positive | transmit_out_negative
               : monitor_in_positive | monitor_in_negative;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) ctl_r <= 8'h00;
    else if (reg_wr && reg_addr == ADDR_CONTROL) ctl_r <= reg_wdata;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) snap_r <= 23'h7fffff;
    else snap_r <= snap;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) idle_r <= 8'h00;
    else if (tx_bit_tick)
      idle_r <= pulse ? 8'h00 : idle_r + {7'h00, idle_r < 8'h80};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside an answer");
  fl_level_a: assert property (
    calm && ctl_r[CTL_JA_EN] |=> reg_rdata[BIT_FL] == $past(near))
    else $error("fifo limit bit wrong");
  fl_off_a: assert property (
    calm && !ctl_r[CTL_JA_EN] |-> ##1 !reg_rdata[BIT_FL])
    else $error("fifo limit set while attenuator off");
  los_ds3_a: assert property (
    calm && !ctl_r[CTL_E3] && analog_los |=> reg_rdata[BIT_LOS])
    else $error("analog loss not reported");
  los_e3_a: assert property (
    calm && ctl_r[CTL_E3] |=> reg_rdata[BIT_LOS] == $past(g775_los))
    else $error("e3 loss of signal wrong");
  dmo_early_a: assert property (
    calm && idle_r == 8'h7f |=> !reg_rdata[0])
    else $error("drive alarm before its count");
  dmo_set_a: assert property (
    calm && idle_r == 8'h80 |=> reg_rdata[0])
    else $error("drive alarm missing");
  dmo_clr_a: assert property (calm && idle_r == 8'h00 |=> !reg_rdata[0])
    else $error("drive alarm not cleared");
  cover property (calm && idle_r == 8'h80);
  cover property (calm && near && ctl_r[CTL_JA_EN]);
  cover property (calm && ctl_r[CTL_E3] && g775_los);
endmodule : clam_monitor

bind clam_alarm_monitor clam_monitor clam_monitor_i (.mclk, .resetn,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .analog_los,
  .g775_los, .ja_fill, .ja_depth, .tx_bit_tick, .transmit_out_positive,
  .transmit_out_negative, .monitor_in_positive, .monitor_in_negative);

// ==== dv/testbench.sv ====
module testbench import clam_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic resetn, reg_wr, reg_rd, analog_los, g775_los, ref_tick, irq;
  logic rx_on, rx_slow, tx_on, mon_link, rx_bit_tick, rx_pulse, tx_bit_tick;
  logic tp, tn, mp, mn;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [5:0] ja_fill, ja_depth;
  logic [5:0] fills [6] = '{6'h10, 6'h02, 6'h03, 6'h1e, 6'h1d, 6'h00};
  logic [7:0] fl_exp [6] = '{8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08};
  logic [3:0] los_tab [5] = '{4'h5, 4'h2, 4'hb, 4'hc, 4'h0};
  int mismatches = 0;
  int num_checks = 0;
  int k;
  always #5 mclk = ~mclk;
  clam_alarm_monitor clam_alarm_monitor_i (.mclk, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_bit_tick, .rx_pulse,
    .analog_los, .g775_los, .ref_tick, .ja_fill, .ja_depth, .tx_bit_tick,
    .transmit_out_positive(tp), .transmit_out_negative(tn),
    .monitor_in_positive(mp), .monitor_in_negative(mn), .irq);
  clam_line_model clam_line_model_i (.mclk, .resetn, .rx_on, .rx_slow,
    .tx_on, .mon_link, .rx_bit_tick, .rx_pulse, .tx_bit_tick,
    .transmit_out_positive(tp), .transmit_out_negative(tn),
    .monitor_in_positive(mp), .monitor_in_negative(mn));
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic st(input string n, input logic [7:0] m, input logic [7:0] e);
    rd(ADDR_STATUS, d);
    chk(n, e, d & m);
  endtask : st
  // Polls the drive alarm; each poll costs two cycles.
  task automatic poll_dmo();
    k = 0;
    do begin
      rd(ADDR_STATUS, d);
      k++;
    end while (d[BIT_DMO] !== 1'b1 && k < 400);
    chk("dmo set", 8'h01, d & 8'h01);
    chk("dmo not early", 8'h01, {7'h00, k >= 250});
  endtask : poll_dmo
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    {resetn, reg_wr, reg_rd, analog_los, g775_los, rx_slow} = 6'h00;
    {rx_on, tx_on, mon_link, ref_tick} = 4'hf;
    {reg_addr, reg_wdata, ja_fill, ja_depth} = {16'h0000, 6'h10, 6'h20};
    wt(4);
    resetn <= 1'b1;
    rd(ADDR_CONTROL, d);
    chk("control reset", CONTROL_RESET, d);
    rd(ADDR_IRQ_MASK, d);
    chk("mask reset", MASK_RESET, d);
    rd(8'h40, d);
    chk("unmapped read", 8'h00, d);
    $display("test reset values done");
    wr(ADDR_CONTROL, 8'h01);
    foreach (fills[i]) begin
      ja_fill <= fills[i];
      wt(3);
      st("fifo limit", 8'h08, fl_exp[i]);
    end
    wr(ADDR_CONTROL, 8'h00);
    wt(3);
    st("fifo limit off", 8'h08, 8'h00);
    $display("test fifo limit done");
    foreach (los_tab[i]) begin
      wr(ADDR_CONTROL, {6'h00, los_tab[i][3], 1'b0});
      analog_los <= los_tab[i][2];
      g775_los <= los_tab[i][1];
      wt(3);
      st("loss of signal", 8'h02, {6'h00, los_tab[i][0], 1'b0});
    end
    rx_on <= 1'b0;
    wt(150);
    st("digital los early", 8'h22, 8'h00);
    wt(50);
    st("digital los", 8'h22, 8'h22);
    rx_on <= 1'b1;
    wt(300);
    st("digital los clear", 8'h22, 8'h00);
    $display("test loss of signal done");
    wr(ADDR_LOL_CFG, 8'h1f);
    rd(ADDR_LOL_CFG, d);
    chk("lock window", 8'h1f, d);
    rx_slow <= 1'b1;
    wt(2100);
    st("loss of lock", 8'h04, 8'h04);
    rx_slow <= 1'b0;
    wt(2100);
    st("lock regained", 8'h04, 8'h00);
    $display("test loss of lock done");
    wr(ADDR_IRQ_STATUS, 8'hff);
    wr(ADDR_CONTROL, 8'h20);
    tx_on <= 1'b0;
    poll_dmo();
    rd(ADDR_IRQ_STATUS, d);
    chk("irq status", 8'h01, d & 8'h01);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(ADDR_IRQ_MASK, 8'h01);
    wt(2);
    chk("irq raised", 8'h01, {7'h00, irq});
    tx_on <= 1'b1;
    wt(10);
    st("dmo clear", 8'h01, 8'h00);
    wr(ADDR_IRQ_STATUS, 8'h01);
    wt(2);
    chk("irq cleared", 8'h00, {7'h00, irq});
    wr(ADDR_STATUS, 8'hff);
    st("status read only", 8'h0f, 8'h00);
    wr(ADDR_CONTROL, 8'h00);
    mon_link <= 1'b0;
    poll_dmo();
    wr(ADDR_CONTROL, 8'h20);
    wt(10);
    st("internal monitor", 8'h01, 8'h00);
    $display("test drive monitor done");
    report_and_stop();
  end
endmodule : testbench

// ==== logic/clam_alarm_monitor.sv ====
// Functional notes
// - The FIFO-limit bit is 1 while the FIFO is two bits from either end.
// - The FIFO-limit bit clears once the fill is over two bits from both.
// - The FIFO-limit bit carries no alarm while the attenuator is off.
// - The loss-of-lock bit sets at a deviation of 0.5% or more.
// - Loss of signal ORs digital and analog in DS3/STS-1, G.775 in E3.
// - The drive alarm sets after 128 pulse-free transmit bit periods.
// - Bipolar pulses are checked at the transmit pads or monitor pair.
// - Alarm status bits are read-only and writes to them do nothing.
// - Digital loss of signal declares after 160 pulse-free bit periods.
// - Digital loss of signal clears at a pulse density of 33% or more.
// - Control bit 5 picks the pads (1) or the monitor inputs (0).
//
// The address map and the strobed register port are this design's own decisions.
module clam_alarm_monitor
  import clam_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Receive side
  input  wire logic       rx_bit_tick,
  input  wire logic       rx_pulse,
  input  wire logic       analog_los,
  input  wire logic       g775_los,
  input  wire logic       ref_tick,
  // Jitter attenuator FIFO fill and depth
  input  wire logic [5:0] ja_fill,
  input  wire logic [5:0] ja_depth,
  // Transmit side
  input  wire logic       tx_bit_tick,
  input  wire logic       transmit_out_positive,
  input  wire logic       transmit_out_negative,
  input  wire logic       monitor_in_positive,
  input  wire logic       monitor_in_negative,
  // Interrupt
  output logic            irq
);
  logic [7:0]  control_r;
  logic [7:0]  irq_status_r;
  logic [7:0]  irq_mask_r;
  logic [15:0] lol_window_r;
  logic        fifo_limit_alarm_r;
  logic        loss_of_lock_r;
  logic        digital_los_r;
  logic        loss_of_signal_r;
  logic        drive_monitor_alarm;
  logic [7:0]  status;
  logic [7:0]  status_prev_r;
  logic        dmo_pulse;
  logic        ja_enabled;
  logic        e3_mode;

  assign ja_enabled = control_r[CTL_JA_EN];
  assign e3_mode    = control_r[CTL_E3];

  // In this block software writes steer only the control, mask and window registers.
  // The status word has no storage of its own, so a write to its offset
  // simply falls into the default branch and is lost.
  // The lock window is written in units of 32 reference ticks.
  // That keeps the register at eight bits while still reaching windows
  // long enough for a fine frequency compare.
  // A window of zero wraps to the longest count of 65536 ticks and is left to
  // software to avoid; it does no harm beyond a lock bit that is always set.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      control_r    <= CONTROL_RESET;
      irq_mask_r   <= MASK_RESET;
      lol_window_r <= LOL_WINDOW_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_CONTROL: control_r    <= reg_wdata;
        ADDR_IRQ_MASK: irq_mask_r  <= reg_wdata;
        ADDR_LOL_CFG: lol_window_r <= {8'h00, reg_wdata} << 5;
        default: ;
      endcase
    end
  end

  // FIFO within two bit periods of either end raises the limit alarm.
  // The compare is a plain level, so the alarm clears on the first cycle
  // in which the fill has moved clear of both margins.
  // The fill and depth are taken as already synchronous to this clock.
  // The flag is registered, so it trails the fill by one cycle.
  // Gating with the enable makes a disabled attenuator report nothing,
  // whatever fill value its idle FIFO happens to show.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fifo_limit_alarm_r <= 1'b0;
    end else begin
      fifo_limit_alarm_r <= ja_enabled &&
        ((ja_fill <= 6'(FIFO_MARGIN)) ||
         (ja_fill + 6'(FIFO_MARGIN) >= ja_depth));
    end
  end

  // Recovered-clock ticks are counted over a window of reference ticks.
  // The reference tick already comes from the oscillator or synthesizer.
  // The tolerance is the window divided by 200, which is the 0.5% step.
  // A longer window gives a finer compare but a slower verdict; the bit
  // is only refreshed at the end of each window.
  // Both counters restart together at the window end.
  // The recovered tick of the closing cycle opens the next count so that
  // no tick is lost between windows.
  // Sixteen bits hold the longest window that software can program.
  logic [15:0] ref_cnt_r;
  logic [15:0] rec_cnt_r;
  logic [15:0] diff;
  logic [15:0] tol;
  assign diff = (rec_cnt_r > ref_cnt_r) ? rec_cnt_r - ref_cnt_r
                                        : ref_cnt_r - rec_cnt_r;
  assign tol  = lol_window_r / 16'd200;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ref_cnt_r      <= 16'h0000;
      rec_cnt_r      <= 16'h0000;
      loss_of_lock_r <= 1'b0;
    end else if (ref_tick && ref_cnt_r >= lol_window_r - 16'h0001) begin
      loss_of_lock_r <= (diff >= tol);
      ref_cnt_r      <= 16'h0000;
      rec_cnt_r      <= {15'h0000, rx_bit_tick};
    end else begin
      ref_cnt_r <= ref_cnt_r + {15'h0000, ref_tick};
      rec_cnt_r <= rec_cnt_r + {15'h0000, rx_bit_tick};
    end
  end

  // Digital loss of signal: declare on a long gap, clear on density.
  // Declaring and clearing use different measures on purpose: a single
  // stray pulse ends a gap but cannot by itself clear the defect.
  // Density is judged over fixed windows of bits rather than a sliding
  // sum, which costs a little latency but needs only two counters.
  logic [7:0] gap_r;
  logic [6:0] win_r;
  logic [6:0] ones_r;
  logic       win_end;
  logic       dense;

  assign win_end = win_r >= 7'(DENS_WINDOW - 1);
  assign dense   = (ones_r + {6'h00, rx_pulse}) >= 7'(DENS_PULSES);

  // The gap count saturates so that a dead line never wraps it.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gap_r <= 8'h00;
    end else if (rx_bit_tick) begin
      if (rx_pulse) begin
        gap_r <= 8'h00;
      end else if (gap_r < 8'(DLOS_BITS)) begin
        gap_r <= gap_r + 8'h01;
      end
    end
  end

  // Window position and pulse count restart together at a window end.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      win_r  <= 7'h00;
      ones_r <= 7'h00;
    end else if (rx_bit_tick) begin
      if (win_end) begin
        win_r  <= 7'h00;
        ones_r <= 7'h00;
      end else begin
        win_r  <= win_r + 7'h01;
        ones_r <= ones_r + {6'h00, rx_pulse};
      end
    end
  end

  // A dense window wins over a gap that ends in the same bit.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      digital_los_r <= 1'b0;
    end else if (rx_bit_tick) begin
      if (win_end && dense) begin
        digital_los_r <= 1'b0;
      end else if (!rx_pulse && gap_r >= 8'(DLOS_BITS - 1)) begin
        digital_los_r <= 1'b1;
      end
    end
  end

  // In E3 only the G.775 detector counts; the DS3/STS-1 detectors may
  // still run but must not leak into the combined bit.
  // The analog detector already carries its own hysteresis.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      loss_of_signal_r <= 1'b0;
    end else begin
      loss_of_signal_r <= e3_mode ? g775_los
                                  : (digital_los_r | analog_los);
    end
  end

  // A bipolar pulse is either polarity at the chosen monitor point.
  // With external monitoring selected, an unconnected monitor pair shows
  // no pulses and so raises the alarm; that is the intended warning.
  // The pins are looked at only on transmit bit ticks, inside the
  // counter, so a level between ticks does not count as a pulse.
  // The select takes effect on the next tick without clearing the count.
  assign dmo_pulse = control_r[CTL_DMO_INT]
    ? (transmit_out_positive | transmit_out_negative)
    : (monitor_in_positive | monitor_in_negative);

  clam_pulse_counter #(
    .LIMIT (DMO_BITS)
  ) u_dmo (
    .mclk       (mclk),
    .resetn     (resetn),
    .bit_tick   (tx_bit_tick),
    .pulse_seen (dmo_pulse),
    .alarm_r    (drive_monitor_alarm)
  );

  // The status word is assembled live from the alarm flags, so a read
  // always shows the present state and nothing has to be cleared.
  // The per-detector bits are forced low in E3, where they do not apply.
  always_comb begin
    status           = 8'h00;
    status[BIT_DMO]  = drive_monitor_alarm;
    status[BIT_LOS]  = loss_of_signal_r;
    status[BIT_LOL]  = loss_of_lock_r;
    status[BIT_FL]   = fifo_limit_alarm_r;
    status[BIT_ALOS] = analog_los & ~e3_mode;
    status[BIT_DLOS] = digital_los_r & ~e3_mode;
  end

  // The previous status word marks rising alarms for the sticky bits.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_prev_r <= 8'h00;
    end else begin
      status_prev_r <= status;
    end
  end

  // Rising alarms latch; set wins over a write-one clear.
  // An alarm that is still standing does not set its bit again after a
  // clear; software learns of it from the live status word instead.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_status_r  <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == ADDR_IRQ_STATUS) begin
        irq_status_r <= (irq_status_r & ~reg_wdata)
                        | (status & ~status_prev_r);
      end else begin
        irq_status_r <= irq_status_r | (status & ~status_prev_r);
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    // The request is registered, so it trails a mask change by a cycle.
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    // Read data stand for one cycle only and are zero otherwise, so an
    // idle bus never shows stale register contents.
    // The lock window reads back in the same units in which it is written.
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS:     reg_rdata <= status;
        ADDR_CONTROL:    reg_rdata <= control_r;
        ADDR_IRQ_STATUS: reg_rdata <= irq_status_r;
        ADDR_IRQ_MASK:   reg_rdata <= irq_mask_r;
        ADDR_LOL_CFG:    reg_rdata <= lol_window_r[12:5];
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : clam_alarm_monitor

// ==== logic/clam_pulse_counter.sv ====
// Counts bit periods with no pulse; alarm after LIMIT, cleared on a pulse.
module clam_pulse_counter
  import clam_pkg::*;
#(
  parameter int LIMIT = 128
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Line events
  input  wire logic bit_tick,
  input  wire logic pulse_seen,
  // Result
  output logic      alarm_r
);
  logic [8:0] quiet_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      quiet_r <= 9'h000;
      alarm_r <= 1'b0;
    end else if (bit_tick) begin
      if (pulse_seen) begin
        quiet_r <= 9'h000;
        alarm_r <= 1'b0;
      end else if (quiet_r >= 9'(LIMIT - 1)) begin
        alarm_r <= 1'b1;
      end else begin
        quiet_r <= quiet_r + 9'h001;
      end
    end
  end
endmodule : clam_pulse_counter

// ==== shared/clam_pkg.sv ====
package clam_pkg;
  // Register map of the plain register port (byte offsets).
  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_CONTROL    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0c;
  localparam logic [7:0] ADDR_LOL_CFG    = 8'h10;

  // Alarm status bit positions.
  localparam int BIT_DMO  = 0;
  localparam int BIT_LOS  = 1;
  localparam int BIT_LOL  = 2;
  localparam int BIT_FL   = 3;
  localparam int BIT_ALOS = 4;
  localparam int BIT_DLOS = 5;

  // Control register bit positions.
  localparam int CTL_JA_EN   = 0;
  localparam int CTL_E3      = 1;
  localparam int CTL_SFM     = 2;
  localparam int CTL_DMO_INT = 5;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;

  // Bit-period counts.
  localparam int FIFO_MARGIN    = 2;
  localparam int DMO_BITS       = 128;
  localparam int DLOS_BITS      = 160;
  // Pulse density for clearing: at least 33 in a window of 100 bits.
  localparam int DENS_WINDOW    = 100;
  localparam int DENS_PULSES    = 33;
  // Lock compare: window of reference edges, deviation of 0.5% = 1/200.
  localparam int LOL_PPM        = 5000;
  localparam int LOL_WINDOW     = 4000;
  localparam int LOL_TOL        = LOL_WINDOW * LOL_PPM / 1000000;
  localparam logic [15:0] LOL_WINDOW_RESET = 16'(LOL_WINDOW);
endpackage : clam_pkg
